// file: hw/video_mode_regs.vh
`ifndef VIDEO_MODE_REGS_VH
`define VIDEO_MODE_REGS_VH

// Subaddresses of the register group.
`define INPUT_MODE_SELECT_ADDR 8'h01
`define OUTPUT_MODE_CONTROL_ADDR 8'h02
`define MATRIX_COEF_LSB_A_ADDR 8'h03
`define MATRIX_COEF_LSB_B_ADDR 8'h04
`define MATRIX_COEF_GREEN_LUMA_MSB_ADDR 8'h05
`define MATRIX_COEF_GREEN_U_MSB_ADDR 8'h06
`define MATRIX_COEF_GREEN_V_MSB_ADDR 8'h07
`define MATRIX_COEF_BLUE_U_MSB_ADDR 8'h08
`define MATRIX_COEF_RED_V_MSB_ADDR 8'h09

// Reset values.
`define INPUT_MODE_SELECT_RST 8'h00
`define OUTPUT_MODE_CONTROL_RST 8'h20
`define MATRIX_COEF_LSB_A_RST 8'h03
`define MATRIX_COEF_LSB_B_RST 8'hf0
`define MATRIX_COEF_GREEN_LUMA_MSB_RST 8'h4e
`define MATRIX_COEF_GREEN_U_MSB_RST 8'h0e
`define MATRIX_COEF_GREEN_V_MSB_RST 8'h24
`define MATRIX_COEF_BLUE_U_MSB_RST 8'h92
`define MATRIX_COEF_RED_V_MSB_RST 8'h7c

// Writable bits; reserved bits are held at zero and read as zero.
`define INPUT_MODE_SELECT_MASK 8'hf6
`define OUTPUT_MODE_CONTROL_MASK 8'hfc
`define MATRIX_COEF_LSB_A_MASK 8'h03

// Field positions.
`define EDGE_ALIGN_HI 2
`define EDGE_ALIGN_LO 1
`define INPUT_MODE_HI 6
`define INPUT_MODE_LO 4
`define BUS_SWAP_BIT 7
`define BLACK_BAR_BIT 2
`define MATRIX_MANUAL_BIT 3
`define SYNC_ON_RGB_BIT 4
`define YPRPB_SELECT_BIT 5
`define SD_SYNC_OUT_BIT 6
`define EDHD_SYNC_OUT_BIT 7

// Edge alignment codes.
`define EDGE_CHROMA_RISE 2'h0
`define EDGE_LUMA_RISE 2'h3

// Input mode codes.
`define MODE_SD_ONLY 3'h0
`define MODE_EDHD_SDR 3'h1
`define MODE_EDHD_DDR 3'h2
`define MODE_SD_EDHD_SDR 3'h3
`define MODE_SD_EDHD_DDR 3'h4
`define MODE_ED_54 3'h7

// Built-in matrix used while manual adjustment is off.
`define COEF_GREEN_LUMA_DEF 10'h13b
`define COEF_GREEN_U_DEF 10'h03b
`define COEF_GREEN_V_DEF 10'h093
`define COEF_BLUE_U_DEF 10'h248
`define COEF_RED_V_DEF 10'h1f0

`endif

// file: hw/input_capture_align.v
`timescale 1ns/1ps
`include "video_mode_regs.vh"

module input_capture_align #(
  parameter PIX_W = 10
) (
  // Clock and reset.
  input wire clock,
  input wire srst,
  // Configuration.
  input wire [2:0] input_mode,
  input wire [1:0] edge_align,
  input wire bus_swap,
  // Pixel buses.
  input wire [PIX_W-1:0] pix_s,
  input wire [PIX_W-1:0] pix_y,
  input wire [PIX_W-1:0] pix_c,
  input wire [PIX_W-1:0] ddr_rise,
  input wire [PIX_W-1:0] ddr_fall,
  // Captured data.
  output reg [PIX_W-1:0] sd_data_q,
  output reg [PIX_W-1:0] edhd_luma_q,
  output reg [PIX_W-1:0] edhd_chroma_q,
  output reg sd_path_en_q,
  output reg edhd_path_en_q,
  output reg edhd_ddr_q,
  output reg ed_54_q
);

  wire sd_on;
  wire ddr_on;
  wire sdr_on;
  wire ed54_on;

  assign sd_on = (input_mode == `MODE_SD_ONLY) || (input_mode == `MODE_SD_EDHD_SDR) ||
                 (input_mode == `MODE_SD_EDHD_DDR);
  assign ddr_on = (input_mode == `MODE_EDHD_DDR) || (input_mode == `MODE_SD_EDHD_DDR);
  assign sdr_on = (input_mode == `MODE_EDHD_SDR) || (input_mode == `MODE_SD_EDHD_SDR);
  assign ed54_on = (input_mode == `MODE_ED_54);

  always @(posedge clock) begin
    if (srst) begin
      sd_data_q <= {PIX_W{1'b0}};
      edhd_luma_q <= {PIX_W{1'b0}};
      edhd_chroma_q <= {PIX_W{1'b0}};
      sd_path_en_q <= 1'b0;
      edhd_path_en_q <= 1'b0;
      edhd_ddr_q <= 1'b0;
      ed_54_q <= 1'b0;
    end else begin
      sd_path_en_q <= sd_on;
      edhd_path_en_q <= ddr_on | sdr_on | ed54_on;
      edhd_ddr_q <= ddr_on;
      ed_54_q <= ed54_on;
      // The swap only moves the SD source; ED/HD buses keep their places.
      sd_data_q <= bus_swap ? pix_y : pix_s;
      if (ddr_on) begin
        // Reserved alignment codes behave as the chroma-on-rising code.
        if (edge_align == `EDGE_LUMA_RISE) begin
          edhd_luma_q <= ddr_rise;
          edhd_chroma_q <= ddr_fall;
        end else begin
          edhd_chroma_q <= ddr_rise;
          edhd_luma_q <= ddr_fall;
        end
      end else begin
        edhd_luma_q <= pix_y;
        edhd_chroma_q <= pix_c;
      end
    end
  end

endmodule // input_capture_align

// file: hw/output_sync_select.v
`timescale 1ns/1ps

module output_sync_select (
  // Clock and reset.
  input wire clock,
  input wire srst,
  // Configuration.
  input wire sd_sync_out_en,
  input wire edhd_sync_out_en,
  input wire black_bar,
  input wire edhd_tp_en,
  input wire sd_tp_en,
  // Timing generator syncs.
  input wire sd_hsync,
  input wire sd_vsync,
  input wire edhd_hsync,
  input wire edhd_vsync,
  // Sync pins and test pattern controls.
  output reg sync_hsync_q,
  output reg sync_vsync_q,
  output reg edhd_black_bar_q,
  output reg sd_black_bar_q
);

  always @(posedge clock) begin
    if (srst) begin
      sync_hsync_q <= 1'b0;
      sync_vsync_q <= 1'b0;
      edhd_black_bar_q <= 1'b0;
      sd_black_bar_q <= 1'b0;
    end else begin
      // Both sources share the pins; ED/HD wins when both are enabled.
      if (edhd_sync_out_en) begin
        sync_hsync_q <= edhd_hsync;
        sync_vsync_q <= edhd_vsync;
      end else if (sd_sync_out_en) begin
        sync_hsync_q <= sd_hsync;
        sync_vsync_q <= sd_vsync;
      end else begin
        sync_hsync_q <= 1'b0;
        sync_vsync_q <= 1'b0;
      end
      edhd_black_bar_q <= black_bar & edhd_tp_en;
      sd_black_bar_q <= black_bar & sd_tp_en;
    end
  end

endmodule // output_sync_select

// file: hw/video_mode_csc_config_regs.v
`timescale 1ns/1ps
`include "video_mode_regs.vh"

module video_mode_csc_config_regs #(
  parameter PIX_W = 10
) (
  // Clock and reset.
  input wire clock,
  input wire srst,
  // Control port, byte level.
  input wire sub_wr,
  input wire dat_wr,
  input wire dat_rd,
  input wire [7:0] wr_byte,
  output reg [7:0] rd_byte_q,
  output reg rd_valid_q,
  // Pixel input buses.
  input wire [PIX_W-1:0] pix_s,
  input wire [PIX_W-1:0] pix_y,
  input wire [PIX_W-1:0] pix_c,
  input wire [PIX_W-1:0] ddr_rise,
  input wire [PIX_W-1:0] ddr_fall,
  // Test pattern enables held elsewhere in the device.
  input wire edhd_tp_en,
  input wire sd_tp_en,
  // Timing generator syncs.
  input wire sd_hsync,
  input wire sd_vsync,
  input wire edhd_hsync,
  input wire edhd_vsync,
  // Captured pixel data and path controls.
  output wire [PIX_W-1:0] sd_data_q,
  output wire [PIX_W-1:0] edhd_luma_q,
  output wire [PIX_W-1:0] edhd_chroma_q,
  output wire sd_path_en_q,
  output wire edhd_path_en_q,
  output wire edhd_ddr_q,
  output wire ed_54_q,
  output reg cfg_reserved_q,
  // Output stage controls.
  output reg sync_on_rgb_q,
  output reg ypbpr_select_q,
  output reg matrix_manual_q,
  output wire edhd_black_bar_q,
  output wire sd_black_bar_q,
  output wire sync_hsync_q,
  output wire sync_vsync_q,
  // Colour space converter coefficients in use.
  output reg [9:0] coef_green_luma_q,
  output reg [9:0] coef_green_u_q,
  output reg [9:0] coef_green_v_q,
  output reg [9:0] coef_blue_u_q,
  output reg [9:0] coef_red_v_q
);

  // Subaddress pointer and the nine stored registers.
  reg [7:0] sub_ptr_q;
  reg [7:0] input_mode_select_q;
  reg [7:0] output_mode_control_q;
  reg [7:0] matrix_coef_lsb_a_q;
  reg [7:0] matrix_coef_lsb_b_q;
  reg [7:0] matrix_coef_green_luma_msb_q;
  reg [7:0] matrix_coef_green_u_msb_q;
  reg [7:0] matrix_coef_green_v_msb_q;
  reg [7:0] matrix_coef_blue_u_msb_q;
  reg [7:0] matrix_coef_red_v_msb_q;

  // Coefficients assembled from the stored bytes.
  wire [9:0] prog_green_luma;
  wire [9:0] prog_green_u;
  wire [9:0] prog_green_v;
  wire [9:0] prog_blue_u;
  wire [9:0] prog_red_v;
  wire manual_en;
  wire rd_take;

  // A subaddress load in the same cycle refuses any data access.
  assign rd_take = dat_rd & ~sub_wr;

  // Addresses outside this group read as zero and ignore writes.
  function [7:0] read_mux;
    input [7:0] addr;
    input [7:0] r1;
    input [7:0] r2;
    input [7:0] r3;
    input [7:0] r4;
    input [7:0] r5;
    input [7:0] r6;
    input [7:0] r7;
    input [7:0] r8;
    input [7:0] r9;
    begin
      case (addr)
        `INPUT_MODE_SELECT_ADDR: read_mux = r1;
        `OUTPUT_MODE_CONTROL_ADDR: read_mux = r2;
        `MATRIX_COEF_LSB_A_ADDR: read_mux = r3;
        `MATRIX_COEF_LSB_B_ADDR: read_mux = r4;
        `MATRIX_COEF_GREEN_LUMA_MSB_ADDR: read_mux = r5;
        `MATRIX_COEF_GREEN_U_MSB_ADDR: read_mux = r6;
        `MATRIX_COEF_GREEN_V_MSB_ADDR: read_mux = r7;
        `MATRIX_COEF_BLUE_U_MSB_ADDR: read_mux = r8;
        `MATRIX_COEF_RED_V_MSB_ADDR: read_mux = r9;
        default: read_mux = 8'h00;
      endcase
    end
  endfunction

  // Flags a reserved edge alignment or input mode code.
  function is_reserved;
    input [7:0] mode_reg;
    reg [1:0] edge_code;
    reg [2:0] mode_code;
    begin
      edge_code = mode_reg[`EDGE_ALIGN_HI:`EDGE_ALIGN_LO];
      mode_code = mode_reg[`INPUT_MODE_HI:`INPUT_MODE_LO];
      is_reserved = 1'b1;
      // Edge codes matter only in the double-rate modes.
      case (mode_code)
        `MODE_SD_ONLY,
        `MODE_EDHD_SDR,
        `MODE_SD_EDHD_SDR,
        `MODE_ED_54: is_reserved = 1'b0;
        `MODE_EDHD_DDR,
        `MODE_SD_EDHD_DDR: is_reserved = (edge_code != `EDGE_CHROMA_RISE) &&
                                         (edge_code != `EDGE_LUMA_RISE);
        default: is_reserved = 1'b1;
      endcase
    end
  endfunction

  // Subaddress pointer and register writes.
  always @(posedge clock) begin
    if (srst) begin
      sub_ptr_q <= 8'h00;
      input_mode_select_q <= `INPUT_MODE_SELECT_RST;
      output_mode_control_q <= `OUTPUT_MODE_CONTROL_RST;
      matrix_coef_lsb_a_q <= `MATRIX_COEF_LSB_A_RST;
      matrix_coef_lsb_b_q <= `MATRIX_COEF_LSB_B_RST;
      matrix_coef_green_luma_msb_q <= `MATRIX_COEF_GREEN_LUMA_MSB_RST;
      matrix_coef_green_u_msb_q <= `MATRIX_COEF_GREEN_U_MSB_RST;
      matrix_coef_green_v_msb_q <= `MATRIX_COEF_GREEN_V_MSB_RST;
      matrix_coef_blue_u_msb_q <= `MATRIX_COEF_BLUE_U_MSB_RST;
      matrix_coef_red_v_msb_q <= `MATRIX_COEF_RED_V_MSB_RST;
    end else if (sub_wr) begin
      // A subaddress load takes precedence over a data access in the same cycle.
      sub_ptr_q <= wr_byte;
    end else if (dat_wr || dat_rd) begin
      // The pointer wraps from 0xff back to 0x00.
      sub_ptr_q <= sub_ptr_q + 8'h01;
      if (dat_wr) begin
        case (sub_ptr_q)
          `INPUT_MODE_SELECT_ADDR: begin
            // Reserved bits 0 and 3 store zero.
            input_mode_select_q <= wr_byte & `INPUT_MODE_SELECT_MASK;
          end
          `OUTPUT_MODE_CONTROL_ADDR: begin
            // Low two bits are forced to zero whatever software writes.
            output_mode_control_q <= wr_byte & `OUTPUT_MODE_CONTROL_MASK;
          end
          `MATRIX_COEF_LSB_A_ADDR: begin
            // Only the luma low pair is stored; bits 7:2 read as zero.
            matrix_coef_lsb_a_q <= wr_byte & `MATRIX_COEF_LSB_A_MASK;
          end
          `MATRIX_COEF_LSB_B_ADDR: begin
            matrix_coef_lsb_b_q <= wr_byte;
          end
          `MATRIX_COEF_GREEN_LUMA_MSB_ADDR: begin
            matrix_coef_green_luma_msb_q <= wr_byte;
          end
          `MATRIX_COEF_GREEN_U_MSB_ADDR: begin
            matrix_coef_green_u_msb_q <= wr_byte;
          end
          `MATRIX_COEF_GREEN_V_MSB_ADDR: begin
            matrix_coef_green_v_msb_q <= wr_byte;
          end
          `MATRIX_COEF_BLUE_U_MSB_ADDR: begin
            matrix_coef_blue_u_msb_q <= wr_byte;
          end
          `MATRIX_COEF_RED_V_MSB_ADDR: begin
            matrix_coef_red_v_msb_q <= wr_byte;
          end
          default: begin
            // Subaddresses outside the group take no write; the pointer still moves.
            sub_ptr_q <= sub_ptr_q + 8'h01;
          end
        endcase
      end
    end
  end

  // Read data is sampled at the pointer before it advances.
  always @(posedge clock) begin
    if (srst) begin
      rd_byte_q <= 8'h00;
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= rd_take;
      if (rd_take) begin
        rd_byte_q <= read_mux(sub_ptr_q, input_mode_select_q, output_mode_control_q,
                              matrix_coef_lsb_a_q, matrix_coef_lsb_b_q,
                              matrix_coef_green_luma_msb_q, matrix_coef_green_u_msb_q,
                              matrix_coef_green_v_msb_q, matrix_coef_blue_u_msb_q,
                              matrix_coef_red_v_msb_q);
      end
    end
  end

  // Coefficient assembly from high byte and packed low pairs.
  assign prog_green_luma = {matrix_coef_green_luma_msb_q, matrix_coef_lsb_a_q[1:0]};
  assign prog_green_u = {matrix_coef_green_u_msb_q, matrix_coef_lsb_b_q[7:6]};
  assign prog_green_v = {matrix_coef_green_v_msb_q, matrix_coef_lsb_b_q[5:4]};
  assign prog_blue_u = {matrix_coef_blue_u_msb_q, matrix_coef_lsb_b_q[3:2]};
  assign prog_red_v = {matrix_coef_red_v_msb_q, matrix_coef_lsb_b_q[1:0]};
  assign manual_en = output_mode_control_q[`MATRIX_MANUAL_BIT];

  // Coefficients handed to the converter, and the static output controls.
  // The stored bytes reset to the built-in matrix, so manual mode alone changes nothing.
  always @(posedge clock) begin
    if (srst) begin
      coef_green_luma_q <= `COEF_GREEN_LUMA_DEF;
      coef_green_u_q <= `COEF_GREEN_U_DEF;
      coef_green_v_q <= `COEF_GREEN_V_DEF;
      coef_blue_u_q <= `COEF_BLUE_U_DEF;
      coef_red_v_q <= `COEF_RED_V_DEF;
      matrix_manual_q <= 1'b0;
      sync_on_rgb_q <= 1'b0;
      ypbpr_select_q <= 1'b1;
      cfg_reserved_q <= 1'b0;
    end else begin
      matrix_manual_q <= manual_en;
      if (manual_en) begin
        coef_green_luma_q <= prog_green_luma;
        coef_green_u_q <= prog_green_u;
        coef_green_v_q <= prog_green_v;
        coef_blue_u_q <= prog_blue_u;
        coef_red_v_q <= prog_red_v;
      end else begin
        coef_green_luma_q <= `COEF_GREEN_LUMA_DEF;
        coef_green_u_q <= `COEF_GREEN_U_DEF;
        coef_green_v_q <= `COEF_GREEN_V_DEF;
        coef_blue_u_q <= `COEF_BLUE_U_DEF;
        coef_red_v_q <= `COEF_RED_V_DEF;
      end
      // Static controls follow the output and input mode registers one clock later.
      sync_on_rgb_q <= output_mode_control_q[`SYNC_ON_RGB_BIT];
      ypbpr_select_q <= output_mode_control_q[`YPRPB_SELECT_BIT];
      cfg_reserved_q <= is_reserved(input_mode_select_q);
    end
  end

  // Pixel capture follows the input mode register.
  input_capture_align #(
    .PIX_W(PIX_W)
  ) u_capture (
    .clock(clock),
    .srst(srst),
    .input_mode(input_mode_select_q[`INPUT_MODE_HI:`INPUT_MODE_LO]),
    .edge_align(input_mode_select_q[`EDGE_ALIGN_HI:`EDGE_ALIGN_LO]),
    .bus_swap(input_mode_select_q[`BUS_SWAP_BIT]),
    .pix_s(pix_s),
    .pix_y(pix_y),
    .pix_c(pix_c),
    .ddr_rise(ddr_rise),
    .ddr_fall(ddr_fall),
    .sd_data_q(sd_data_q),
    .edhd_luma_q(edhd_luma_q),
    .edhd_chroma_q(edhd_chroma_q),
    .sd_path_en_q(sd_path_en_q),
    .edhd_path_en_q(edhd_path_en_q),
    .edhd_ddr_q(edhd_ddr_q),
    .ed_54_q(ed_54_q)
  );

  // Sync pins and black bar controls follow the output mode register.
  output_sync_select u_sync (
    .clock(clock),
    .srst(srst),
    .sd_sync_out_en(output_mode_control_q[`SD_SYNC_OUT_BIT]),
    .edhd_sync_out_en(output_mode_control_q[`EDHD_SYNC_OUT_BIT]),
    .black_bar(output_mode_control_q[`BLACK_BAR_BIT]),
    .edhd_tp_en(edhd_tp_en),
    .sd_tp_en(sd_tp_en),
    .sd_hsync(sd_hsync),
    .sd_vsync(sd_vsync),
    .edhd_hsync(edhd_hsync),
    .edhd_vsync(edhd_vsync),
    .sync_hsync_q(sync_hsync_q),
    .sync_vsync_q(sync_vsync_q),
    .edhd_black_bar_q(edhd_black_bar_q),
    .sd_black_bar_q(sd_black_bar_q)
  );

endmodule // video_mode_csc_config_regs

// file: test/video_mode_csc_config_regs_properties.sv
`timescale 1ns/1ps
module video_mode_csc_config_regs_properties (
  // Clock and reset.
  input wire clock,
  input wire srst,
  // Register port.
  input wire sub_wr,
  input wire dat_rd,
  input wire [7:0] rd_byte_q,
  input wire rd_valid_q,
  // Sources.
  input wire edhd_tp_en,
  input wire sd_tp_en,
  input wire sd_hsync,
  input wire edhd_hsync,
  // Watched outputs.
  input wire sync_hsync_q,
  input wire edhd_black_bar_q,
  input wire sd_black_bar_q,
  input wire sd_path_en_q,
  input wire edhd_path_en_q,
  input wire edhd_ddr_q,
  input wire ed_54_q,
  input wire matrix_manual_q,
  input wire [9:0] coef_green_luma_q,
  input wire [9:0] coef_red_v_q
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);

  sequence rd_taken;
    dat_rd && !sub_wr;
  endsequence
  sequence rd_answer;
    rd_valid_q ##1 $stable(rd_byte_q) || rd_valid_q;
  endsequence

  read_answer_a: assert property (rd_taken |=> rd_answer)
    else $error("read not answered one cycle later");
  load_refuse_a: assert property (sub_wr && dat_rd |=> !rd_valid_q)
    else $error("read taken while pointer loads");
  read_hold_a: assert property (!rd_valid_q |-> $stable(rd_byte_q))
    else $error("read data moved without a read");
  matrix_default_a: assert property (!matrix_manual_q |->
    coef_green_luma_q == 10'h13b && coef_red_v_q == 10'h1f0)
    else $error("built-in matrix not used");
  hsync_source_a: assert property (sync_hsync_q |->
    $past(sd_hsync) || $past(edhd_hsync))
    else $error("sync pin high without a source");
  edhd_bar_a: assert property (edhd_black_bar_q |-> $past(edhd_tp_en))
    else $error("black bar without pattern enable");
  sd_bar_a: assert property (sd_black_bar_q |-> $past(sd_tp_en))
    else $error("sd black bar without pattern enable");
  ed54_paths_a: assert property (ed_54_q |->
    edhd_path_en_q && !sd_path_en_q && !edhd_ddr_q)
    else $error("wrong paths in 54 MHz mode");
  ddr_path_a: assert property (edhd_ddr_q |-> edhd_path_en_q)
    else $error("double rate without its path");
endmodule // video_mode_csc_config_regs_properties

bind video_mode_csc_config_regs video_mode_csc_config_regs_properties i_props (
  .clock, .srst, .sub_wr, .dat_rd, .rd_byte_q, .rd_valid_q, .edhd_tp_en, .sd_tp_en,
  .sd_hsync, .edhd_hsync, .sync_hsync_q, .edhd_black_bar_q, .sd_black_bar_q,
  .sd_path_en_q, .edhd_path_en_q, .edhd_ddr_q, .ed_54_q, .matrix_manual_q,
  .coef_green_luma_q, .coef_red_v_q
);

// file: test/tb_video_mode_csc_config_regs.sv
`timescale 1ns/1ps
module tb_video_mode_csc_config_regs;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic sub_wr = 1'b0;
  logic dat_wr = 1'b0;
  logic dat_rd = 1'b0;
  logic [7:0] wr_byte = 8'h00;
  logic [9:0] pix_s = 10'h000, pix_y = 10'h000, pix_c = 10'h000;
  logic [9:0] ddr_rise = 10'h000, ddr_fall = 10'h000;
  logic edhd_tp_en = 1'b0, sd_tp_en = 1'b0, sd_hsync = 1'b0, sd_vsync = 1'b0;
  logic edhd_hsync = 1'b0, edhd_vsync = 1'b0;
  wire [7:0] rd_byte_q;
  wire [9:0] sd_data_q, edhd_luma_q, edhd_chroma_q;
  wire rd_valid_q, sd_path_en_q, edhd_path_en_q, edhd_ddr_q, ed_54_q, cfg_reserved_q;
  wire sync_on_rgb_q, ypbpr_select_q, matrix_manual_q, edhd_black_bar_q, sd_black_bar_q;
  wire sync_hsync_q, sync_vsync_q;
  wire [9:0] coef_green_luma_q, coef_green_u_q, coef_green_v_q, coef_blue_u_q, coef_red_v_q;
  logic [7:0] regs [0:255];
  logic [7:0] ptr;
  logic [7:0] expq [$];
  logic [7:0] b;
  logic [1:0] e;
  logic [3:0] kk;
  int n_mismatch = 0;
  int num_checks = 0;
  int cycles = 0;

  video_mode_csc_config_regs i_dut (
    .clock, .srst, .sub_wr, .dat_wr, .dat_rd, .wr_byte, .rd_byte_q, .rd_valid_q,
    .pix_s, .pix_y, .pix_c, .ddr_rise, .ddr_fall, .edhd_tp_en, .sd_tp_en,
    .sd_hsync, .sd_vsync, .edhd_hsync, .edhd_vsync, .sd_data_q, .edhd_luma_q,
    .edhd_chroma_q, .sd_path_en_q, .edhd_path_en_q, .edhd_ddr_q, .ed_54_q,
    .cfg_reserved_q, .sync_on_rgb_q, .ypbpr_select_q, .matrix_manual_q,
    .edhd_black_bar_q, .sd_black_bar_q, .sync_hsync_q, .sync_vsync_q,
    .coef_green_luma_q, .coef_green_u_q, .coef_green_v_q, .coef_blue_u_q, .coef_red_v_q
  );

  initial begin
    forever #5 clock = ~clock;
  end

  task automatic conclude();
    if (expq.size() != 0) n_mismatch++;
    if (n_mismatch == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [7:0] wmask(input logic [7:0] a);
    case (a)
      8'h01: return 8'hf6;
      8'h02: return 8'hfc;
      8'h03: return 8'h03;
      8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09: return 8'hff;
      default: return 8'h00;
    endcase
  endfunction

  task automatic model_reset();
    foreach (regs[i]) regs[i] = 8'h00;
    {regs[1], regs[2], regs[3], regs[4], regs[5], regs[6], regs[7], regs[8], regs[9]} =
      72'h00_20_03_f0_4e_0e_24_92_7c;
    ptr = 8'h00;
  endtask

  // One port cycle; the model follows the pointer and the stored bytes.
  task automatic op(input logic s, input logic w, input logic r, input logic [7:0] v);
    @(negedge clock);
    sub_wr = s;
    dat_wr = w;
    dat_rd = r;
    wr_byte = v;
    if (s) ptr = v;
    else if (w || r) begin
      if (r) expq.push_back(regs[ptr]);
      if (w) regs[ptr] = v & wmask(ptr);
      ptr = ptr + 8'h01;
    end
  endtask

  task automatic rd_burst(input logic [7:0] a, input int n);
    op(1'b1, 1'b0, 1'b1, a);
    repeat (n) op(1'b0, 1'b0, 1'b1, 8'($urandom));
    op(1'b0, 1'b0, 1'b0, 8'h00);
  endtask

  task automatic rnd_in();
    logic [63:0] r;
    r = {$urandom, $urandom};
    {pix_s, pix_y, pix_c, ddr_rise, ddr_fall} = r[49:0];
    {edhd_tp_en, sd_tp_en, sd_hsync, sd_vsync, edhd_hsync, edhd_vsync} = r[55:50];
  endtask

  task automatic cfg_check();
    logic [2:0] m;
    logic [1:0] c;
    logic ddr;
    m = regs[1][6:4];
    c = regs[1][2:1];
    ddr = (m == 3'h2 || m == 3'h4);
    op(1'b0, 1'b0, 1'b0, 8'h00);
    repeat (2) @(negedge clock);
    check(sd_path_en_q, m == 3'h0 || m == 3'h3 || m == 3'h4);
    check(edhd_path_en_q, m inside {3'h1, 3'h2, 3'h3, 3'h4, 3'h7});
    check({edhd_ddr_q, ed_54_q}, {ddr, m == 3'h7});
    check(cfg_reserved_q, m == 3'h5 || m == 3'h6 || (ddr && c inside {2'h1, 2'h2}));
    check(sd_data_q, regs[1][7] ? pix_y : pix_s);
    check(edhd_luma_q, !ddr ? pix_y : (c == 2'h3 ? ddr_rise : ddr_fall));
    check(edhd_chroma_q, !ddr ? pix_c : (c == 2'h3 ? ddr_fall : ddr_rise));
    check({ypbpr_select_q, sync_on_rgb_q, matrix_manual_q}, regs[2][5:3]);
    check({edhd_black_bar_q, sd_black_bar_q}, {2{regs[2][2]}} & {edhd_tp_en, sd_tp_en});
    check({sync_hsync_q, sync_vsync_q}, regs[2][7] ? {edhd_hsync, edhd_vsync} :
      (regs[2][6] ? {sd_hsync, sd_vsync} : 2'h0));
    check({coef_green_luma_q, coef_green_u_q, coef_green_v_q, coef_blue_u_q, coef_red_v_q},
      !regs[2][3] ? {10'h13b, 10'h03b, 10'h093, 10'h248, 10'h1f0} :
      {regs[5], regs[3][1:0], regs[6], regs[4][7:6], regs[7], regs[4][5:4],
      regs[8], regs[4][3:2], regs[9], regs[4][1:0]});
  endtask

  always @(negedge clock) begin
    if (rd_valid_q === 1'b1) begin
      if (expq.size() == 0) check(rd_byte_q, 64'hffff);
      else check(rd_byte_q, expq.pop_front());
    end
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      conclude();
    end
  end

  initial begin
    void'($urandom(32'h5277));
    model_reset();
    repeat (20) @(negedge clock);
    srst = 1'b0;
    rnd_in();
    cfg_check();
    // Writes outside the group are dropped; the pointer wraps past 0xff.
    op(1'b1, 1'b0, 1'b0, 8'h00);
    op(1'b0, 1'b1, 1'b0, 8'hff);
    op(1'b1, 1'b0, 1'b0, 8'h0a);
    op(1'b0, 1'b1, 1'b0, 8'hff);
    rd_burst(8'hff, 12);
    for (int k = 0; k < 16; k++) begin
      kk = k[3:0];
      e = kk[3] ? kk[2:1] : {kk[2], kk[2]};
      rnd_in();
      op(1'b1, 1'b0, 1'b0, 8'h01);
      b = 8'($urandom);
      op(1'b0, 1'b1, 1'b0, {b[7], kk[2:0], b[3], e, b[0]});
      b = 8'($urandom);
      op(1'b0, 1'b1, 1'b0, {b[7:2], 2'h0});
      repeat (7) op(1'b0, 1'b1, 1'b0, 8'($urandom));
      cfg_check();
      rd_burst(8'h01, 9);
    end
    // A write and a read in one cycle return the old byte.
    op(1'b1, 1'b0, 1'b0, 8'h05);
    op(1'b0, 1'b1, 1'b1, 8'ha5);
    rd_burst(8'h05, 1);
    cfg_check();
    @(negedge clock);
    srst = 1'b1;
    repeat (2) @(negedge clock);
    model_reset();
    srst = 1'b0;
    rd_burst(8'h02, 1);
    cfg_check();
    repeat (3) @(negedge clock);
    conclude();
  end
endmodule // tb_video_mode_csc_config_regs
